// ==== rtl/rsq_pkg.sv ====
package rsq_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] INIT_OFS = 8'h08;

    localparam int CTRL_BOOST_BIT = 0;
    localparam int CTRL_DISP_BIT = 1;
    localparam int CTRL_CONV_BIT = 2;
    localparam int STAT_RESET_BIT = 0;
    localparam int STAT_RUN_BIT = 1;
    localparam int STAT_WDT_BIT = 2;
    localparam int STAT_PIN_BIT = 3;

    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Core start values
    // ----------------------------------------
    localparam logic [7:0] INIT_STEP = 8'h00;
    localparam logic [3:0] INIT_PAGE = 4'h1;
    localparam logic [3:0] INIT_NEXT_PAGE = 4'h1;
    localparam logic INIT_FLAG = 1'b0;

    // ----------------------------------------
    // Crystal clock division, in crystal edges
    // ----------------------------------------
    localparam int XTAL_HZ = 32768;
    localparam int CONV_DIV = 4;
    localparam int DISP_DIV = 64;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_WAIT_1HZ = 2'b01,
        ST_RUN = 2'b10
    } rsq_seq_e;

    typedef struct packed {
        logic [7:0] program_step_counter;
        logic [3:0] program_page_counter;
        logic [3:0] next_page_pointer;
        logic int_flag;
        logic dec_flag;
    } rsq_core_init_s;

    typedef struct packed {
        logic conv;
        logic disp;
        logic boost;
    } rsq_ctrl_s;

endpackage

// ==== rtl/rsq_xtal_divider.sv ====
`timescale 1ns/1ps
module rsq_xtal_divider #(
    parameter int CONV_DIV = 4,
    parameter int DISP_DIV = 64,
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic xtal_edge,
    // Divided enables
    output logic conv_tick,
    output logic disp_tick
);
    logic [1:0] tick_reg;

    // ----------------------------------------
    // One counter per consumer
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_div
            localparam int D = (i == 0) ? CONV_DIV : DISP_DIV;
            logic [CNT_W-1:0] cnt_reg;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_reg <= '0;
                    tick_reg[i] <= 1'b0;
                end else begin
                    tick_reg[i] <= 1'b0;
                    // Held at zero while off so each start is phase aligned
                    if (!enable) begin
                        cnt_reg <= '0;
                    end else if (xtal_edge) begin
                        if (cnt_reg == CNT_W'(D - 1)) begin
                            cnt_reg <= '0;
                            tick_reg[i] <= 1'b1;
                        end else begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    assign conv_tick = tick_reg[0];
    assign disp_tick = tick_reg[1];
endmodule

// ==== rtl/rsq_initial_reset_sequencer.sv ====
`timescale 1ns/1ps
// Overview of operation
// RL1: Initial reset held while reset pin is high, released when it falls.
// RL2: After release, processor clock stays gated until the 1 Hz signal rises.
// RL3: External source holds reset pin high at least 2.0 ms at power-up.
// RL4: Watchdog runaway detection raises initial reset as a second source.
// RL5: Power-up initialisation must use the pin, never the watchdog.
// RL6: Reset loads step 00H, page and next page 1H, flags cleared.
// RL7: Software switches the boosted analog supply on and off.
// RL8: Boosted supply divides crystal clock for converter and display driver.
// RL9: Software enables boosted supply before converter or display driver.
// RL10: Display generator runs from boosted supply, switched independently.
// RL11: Converter reference starts automatically whenever converter is on.
// RL12: Reset pin is synchronised before it gates the processor clock.
module rsq_initial_reset_sequencer #(
    parameter int CONV_DIV = rsq_pkg::CONV_DIV,
    parameter int DISP_DIV = rsq_pkg::DISP_DIV
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // AXI4-Lite write
    input wire logic [rsq_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read
    input wire logic [rsq_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Reset sources and timing inputs
    input wire logic RESET_PIN,
    input wire logic CRYSTAL_CLOCK_INPUT,
    input wire logic TIMER_1HZ,
    input wire logic WDT_RUNAWAY,
    // Core control
    output logic CORE_RESET,
    output logic CPU_CLK_EN,
    output rsq_pkg::rsq_core_init_s CORE_INIT,
    // Analog power control
    output logic BOOSTED_ANALOG_SUPPLY_ON,
    output logic DISPLAY_GEN_ON,
    output logic CONVERTER_ON,
    output logic CONVERTER_REFERENCE_VOLTAGE_ON,
    output logic CONV_CLK_EN,
    output logic DISP_CLK_EN
);
    import rsq_pkg::*;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        reg_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] pin_s1_reg;
    logic [1:0] pin_s2_reg;
    logic [1:0] pin_s3_reg;
    logic [1:0] pin_f_reg;
    logic xtal_prev_reg;
    logic ext_rst;
    logic xtal_edge;

    // A change only counts once two stages agree, so one-cycle glitches never reset
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            // Reset pin bit starts asserted, so release waits for a real low
            pin_s1_reg <= 2'h1;
            pin_s2_reg <= 2'h1;
            pin_s3_reg <= 2'h1;
            pin_f_reg <= 2'h1;
            xtal_prev_reg <= 1'b0;
        end else begin
            pin_s1_reg <= {CRYSTAL_CLOCK_INPUT, RESET_PIN};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            for (int i = 0; i < 2; i++) begin
                if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                    pin_f_reg[i] <= pin_s3_reg[i]; // RL12
                end
            end
            xtal_prev_reg <= pin_f_reg[1];
        end
    end

    assign ext_rst = pin_f_reg[0];
    assign xtal_edge = pin_f_reg[1] & ~xtal_prev_reg;

    // ----------------------------------------
    // Reset sequencer
    // ----------------------------------------
    rsq_seq_e seq_reg;
    rsq_seq_e seq_next;
    logic init_req;
    logic one_hz_prev_reg;
    logic one_hz_rise;
    logic core_reset_reg;
    logic cpu_clk_en_reg;
    rsq_core_init_s core_init_reg;

    assign init_req = ext_rst | WDT_RUNAWAY; // RL1 RL4
    assign one_hz_rise = TIMER_1HZ & ~one_hz_prev_reg;

    always_comb begin
        seq_next = seq_reg;
        case (seq_reg)
            ST_RESET: begin
                seq_next = ST_WAIT_1HZ; // RL1
            end
            ST_WAIT_1HZ: begin
                if (one_hz_rise) begin
                    seq_next = ST_RUN; // RL2
                end
            end
            ST_RUN: begin
                seq_next = ST_RUN;
            end
            default: begin
                seq_next = ST_RESET;
            end
        endcase
        if (init_req) begin
            seq_next = ST_RESET; // RL1 RL4
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            seq_reg <= ST_RESET;
            one_hz_prev_reg <= 1'b0;
            core_reset_reg <= 1'b1;
            cpu_clk_en_reg <= 1'b0;
        end else begin
            seq_reg <= seq_next;
            one_hz_prev_reg <= TIMER_1HZ;
            core_reset_reg <= (seq_next == ST_RESET); // RL1
            cpu_clk_en_reg <= (seq_next == ST_RUN); // RL2
        end
    end

    // Only the listed core registers get defined values; the rest stay undefined
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            core_init_reg <= {INIT_STEP, INIT_PAGE, INIT_NEXT_PAGE, INIT_FLAG, INIT_FLAG};
        end else if (init_req) begin
            core_init_reg <= {INIT_STEP, INIT_PAGE, INIT_NEXT_PAGE, INIT_FLAG, INIT_FLAG}; // RL6
        end
    end

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    logic aw_ready_reg;
    logic w_ready_reg;
    logic aw_have_reg;
    logic w_have_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_stat;

    assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
    assign wr_ctrl = wr_fire & reg_hit(aw_addr_reg, CTRL_OFS) & w_strb_reg[0];
    assign wr_stat = wr_fire & reg_hit(aw_addr_reg, STAT_OFS) & w_strb_reg[0];

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_ready_reg <= 1'b1;
            aw_have_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (S_AXI_AWVALID && aw_ready_reg) begin
            aw_ready_reg <= 1'b0;
            aw_have_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_ready_reg <= 1'b1;
            aw_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            w_ready_reg <= 1'b1;
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (S_AXI_WVALID && w_ready_reg) begin
            w_ready_reg <= 1'b0;
            w_have_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            w_ready_reg <= 1'b1;
            w_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (reg_hit(aw_addr_reg, CTRL_OFS) || reg_hit(aw_addr_reg, STAT_OFS) ||
                          reg_hit(aw_addr_reg, INIT_OFS)) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Control and status registers
    // ----------------------------------------
    rsq_ctrl_s ctrl_reg;
    logic wdt_cause_reg;

    // Initial reset also turns analog blocks off; reset beats a same-cycle write
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= CTRL_RESET;
        end else if (init_req) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg.boost <= w_data_reg[CTRL_BOOST_BIT]; // RL7
            ctrl_reg.disp <= w_data_reg[CTRL_DISP_BIT]; // RL10
            ctrl_reg.conv <= w_data_reg[CTRL_CONV_BIT];
        end
    end

    // Sticky watchdog cause, write one to clear; a new event wins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wdt_cause_reg <= 1'b0;
        end else if (WDT_RUNAWAY) begin
            wdt_cause_reg <= 1'b1;
        end else if (wr_stat && w_data_reg[STAT_WDT_BIT]) begin
            wdt_cause_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    logic ar_ready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [31:0] stat_word;

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[STAT_RESET_BIT] = core_reset_reg;
        stat_word[STAT_RUN_BIT] = cpu_clk_en_reg;
        stat_word[STAT_WDT_BIT] = wdt_cause_reg;
        stat_word[STAT_PIN_BIT] = ext_rst;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ar_ready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (S_AXI_ARVALID && ar_ready_reg) begin
            ar_ready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            if (reg_hit(S_AXI_ARADDR, CTRL_OFS)) begin
                rdata_reg <= 32'(ctrl_reg);
            end else if (reg_hit(S_AXI_ARADDR, STAT_OFS)) begin
                rdata_reg <= stat_word;
            end else if (reg_hit(S_AXI_ARADDR, INIT_OFS)) begin
                rdata_reg <= 32'(core_init_reg);
            end else begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= RESP_SLVERR;
            end
        end else if (rvalid_reg && S_AXI_RREADY) begin
            ar_ready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Analog power outputs and divided clocks
    // ----------------------------------------
    logic boost_on_reg;
    logic disp_on_reg;
    logic conv_on_reg;
    logic ref_on_reg;

    // Converter is not gated by the boost; ordering is left to software
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            boost_on_reg <= 1'b0;
            disp_on_reg <= 1'b0;
            conv_on_reg <= 1'b0;
            ref_on_reg <= 1'b0;
        end else begin
            boost_on_reg <= ctrl_reg.boost; // RL7
            disp_on_reg <= ctrl_reg.boost & ctrl_reg.disp; // RL10
            conv_on_reg <= ctrl_reg.conv;
            ref_on_reg <= ctrl_reg.conv; // RL11
        end
    end

    // Divider lives in the boost block, so no clocks flow while it is off
    rsq_xtal_divider #(
        .CONV_DIV(CONV_DIV),
        .DISP_DIV(DISP_DIV),
        .CNT_W(8)
    ) u_div (
        .clk(CLK),
        .rst_n(RST_N),
        .enable(ctrl_reg.boost), // RL8
        .xtal_edge(xtal_edge),
        .conv_tick(CONV_CLK_EN),
        .disp_tick(DISP_CLK_EN)
    );

    assign S_AXI_AWREADY = aw_ready_reg;
    assign S_AXI_WREADY = w_ready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = ar_ready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign CORE_RESET = core_reset_reg;
    assign CPU_CLK_EN = cpu_clk_en_reg;
    assign CORE_INIT = core_init_reg;
    assign BOOSTED_ANALOG_SUPPLY_ON = boost_on_reg;
    assign DISPLAY_GEN_ON = disp_on_reg;
    assign CONVERTER_ON = conv_on_reg;
    assign CONVERTER_REFERENCE_VOLTAGE_ON = ref_on_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_pin_holds_reset;
        ext_rst |=> CORE_RESET && !CPU_CLK_EN;
    endproperty
    a_pin_holds_reset: assert property (p_pin_holds_reset) else $error("pin reset dropped"); // RL1

    property p_pin_release;
        $fell(ext_rst) && !WDT_RUNAWAY |=> !CORE_RESET;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("reset not released"); // RL1

    property p_gate_until_1hz;
        seq_reg == ST_WAIT_1HZ && !one_hz_rise |=> !CPU_CLK_EN;
    endproperty
    a_gate_until_1hz: assert property (p_gate_until_1hz) else $error("clock ran early"); // RL2

    property p_start_on_1hz;
        seq_reg == ST_WAIT_1HZ && $rose(TIMER_1HZ) && !init_req |=> CPU_CLK_EN;
    endproperty
    a_start_on_1hz: assert property (p_start_on_1hz) else $error("clock did not start"); // RL2

    property p_watchdog_reset;
        WDT_RUNAWAY |=> CORE_RESET && !CPU_CLK_EN && ctrl_reg == CTRL_RESET;
    endproperty
    a_watchdog_reset: assert property (p_watchdog_reset) else $error("watchdog ignored"); // RL4

    property p_init_values;
        CORE_RESET |-> CORE_INIT.program_step_counter == INIT_STEP &&
            CORE_INIT.program_page_counter == INIT_PAGE &&
            CORE_INIT.next_page_pointer == INIT_NEXT_PAGE && !CORE_INIT.int_flag &&
            !CORE_INIT.dec_flag;
    endproperty
    a_init_values: assert property (p_init_values) else $error("bad start values"); // RL6

    property p_boost_write;
        wr_ctrl && !init_req |-> ##2 BOOSTED_ANALOG_SUPPLY_ON == $past(w_data_reg[0], 2);
    endproperty
    a_boost_write: assert property (p_boost_write) else $error("boost not switched"); // RL7

    property p_clocks_need_boost;
        (CONV_CLK_EN || DISP_CLK_EN) |-> BOOSTED_ANALOG_SUPPLY_ON;
    endproperty
    a_clocks_need_boost: assert property (p_clocks_need_boost) else $error("tick no boost"); // RL8

    property p_disp_from_boost;
        DISPLAY_GEN_ON |-> BOOSTED_ANALOG_SUPPLY_ON;
    endproperty
    a_disp_from_boost: assert property (p_disp_from_boost) else $error("display no boost"); // RL10

    property p_ref_follows_conv;
        CONVERTER_ON == CONVERTER_REFERENCE_VOLTAGE_ON;
    endproperty
    a_ref_follows_conv: assert property (p_ref_follows_conv) else $error("ref mismatch"); // RL11

    property p_reset_cause;
        $rose(CORE_RESET) |-> $past(ext_rst) || $past(WDT_RUNAWAY);
    endproperty
    a_reset_cause: assert property (p_reset_cause) else $error("reset without cause"); // RL1 RL4

    c_cpu_starts: cover property ($rose(CPU_CLK_EN));
    c_wdt_reset: cover property (CPU_CLK_EN ##1 WDT_RUNAWAY ##1 CORE_RESET);
    c_conv_clock: cover property (CONVERTER_ON && CONV_CLK_EN);
    c_disp_clock: cover property (DISPLAY_GEN_ON && DISP_CLK_EN);
endmodule

// ==== tb/rsq_partner.sv ====
`timescale 1ns/1ps
module rsq_partner #(
    parameter int HOLD_CYC = 300,
    parameter int XT_HALF = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench requests
    input wire logic pin_req,
    input wire logic tick_req,
    input wire logic wdt_req,
    // Far side signals
    output logic reset_pin,
    output logic xtal,
    output logic timer_1hz,
    output logic wdt_runaway,
    output logic up_done
);
    int hold_cnt;
    int xt_cnt;
    // ----
    // Scaled power-up hold, the real one is far too long to simulate
    // ----
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt <= 0;
            up_done <= 1'b0;
        end else begin
            if (hold_cnt < HOLD_CYC) hold_cnt <= hold_cnt + 1;
            up_done <= (hold_cnt >= HOLD_CYC);
        end
    end
    assign reset_pin = !up_done || pin_req;
    assign wdt_runaway = up_done && wdt_req;
    // Crystal runs free once the bench leaves reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal <= 1'b0;
            xt_cnt <= 0;
            timer_1hz <= 1'b0;
        end else begin
            timer_1hz <= tick_req;
            xt_cnt <= (xt_cnt >= XT_HALF - 1) ? 0 : xt_cnt + 1;
            if (xt_cnt >= XT_HALF - 1) xtal <= !xtal;
        end
    end
endmodule

// ==== tb/initial_reset_sequencer_tb.sv ====
`timescale 1ns/1ps
module initial_reset_sequencer_tb;
    import rsq_pkg::*;
    localparam int CDIV = 2;
    localparam int DDIV = 4;
    logic clk = 0;
    logic rst_n = 0;
    logic [7:0] awaddr = 0;
    logic [7:0] araddr = 0;
    logic [31:0] wdata = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic pin_req = 0, tick_req = 0, wdt_req = 0;
    logic reset_pin, xtal, t1hz, wdt, up_done;
    logic core_reset, cpu_en, boost, disp, conv, vref, cclk, dclk;
    rsq_core_init_s core_init;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int ctrl_m;
    always #5 clk = ~clk;
    rsq_partner p (.clk(clk), .rst_n(rst_n), .pin_req(pin_req), .tick_req(tick_req),
        .wdt_req(wdt_req), .reset_pin(reset_pin), .xtal(xtal), .timer_1hz(t1hz),
        .wdt_runaway(wdt), .up_done(up_done));
    rsq_initial_reset_sequencer #(.CONV_DIV(CDIV), .DISP_DIV(DDIV)) dut (
        .CLK(clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .RESET_PIN(reset_pin), .CRYSTAL_CLOCK_INPUT(xtal), .TIMER_1HZ(t1hz),
        .WDT_RUNAWAY(wdt), .CORE_RESET(core_reset), .CPU_CLK_EN(cpu_en),
        .CORE_INIT(core_init), .BOOSTED_ANALOG_SUPPLY_ON(boost), .DISPLAY_GEN_ON(disp),
        .CONVERTER_ON(conv), .CONVERTER_REFERENCE_VOLTAGE_ON(vref),
        .CONV_CLK_EN(cclk), .DISP_CLK_EN(dclk));
    // ----
    // Helpers
    // ----
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 0;
                n = 99;
            end
        end
        if (n != 99) chk("wr timeout", 1, 0);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 0;
                n = 99;
            end
        end
        if (n != 99) chk("rd timeout", 1, 0);
    endtask
    task automatic wait_rst(input logic v);
        int n;
        n = 0;
        while (core_reset !== v && n < 30) begin
            @(posedge clk);
            n++;
        end
        chk("core_reset", v, core_reset);
    endtask
    // A 1 Hz rise, held long enough for sync and gate
    task automatic tick();
        @(posedge clk);
        tick_req <= 1;
        repeat (6) @(posedge clk);
        tick_req <= 0;
    endtask
    task automatic count(input int c, output int xr, output int pc, output int pd);
        logic xp;
        xr = 0;
        pc = 0;
        pd = 0;
        xp = xtal;
        repeat (c) begin
            @(posedge clk);
            xr += (xtal && !xp);
            xp = xtal;
            pc += cclk;
            pd += dclk;
        end
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        logic [1:0] r;
        logic [31:0] d;
        int base, xr, pc, pd;
        void'($urandom(32'h971b_d1c7));
        repeat (2) @(posedge clk);
        rst_n <= 1;
        repeat (20) @(posedge clk);
        chk("reset held by pin", 1, core_reset);
        tick();
        chk("cpu_en in reset", 0, cpu_en);
        while (!up_done) @(posedge clk);
        wait_rst(0);
        chk("core_init", {8'h00, 4'h1, 4'h1, 1'b0, 1'b0}, core_init);
        repeat (10) @(posedge clk);
        chk("cpu_en wait 1hz", 0, cpu_en);
        tick();
        chk("cpu_en run", 1, cpu_en);
        rd(INIT_OFS, d, r);
        chk("init reg", {8'h00, 4'h1, 4'h1, 1'b0, 1'b0}, d);
        $display("test power_up done");
        base = $urandom % 8;
        for (int i = 0; i < 8; i++) begin
            ctrl_m = (base + i) % 8;
            wr(CTRL_OFS, ctrl_m, r);
            chk("ctrl bresp", RESP_OKAY, r);
            repeat (2) @(posedge clk);
            chk("boost", ctrl_m & 1, boost);
            chk("disp gen", (ctrl_m & 3) == 3, disp);
            chk("conv", ctrl_m >> 2, conv);
            chk("vref", ctrl_m >> 2, vref);
            rd(CTRL_OFS, d, r);
            chk("ctrl rd", ctrl_m, d);
        end
        wr(8'h0C, $urandom, r);
        chk("unmapped wr", RESP_SLVERR, r);
        rd(8'h10, d, r);
        chk("unmapped rd", RESP_SLVERR, r);
        chk("unmapped rdata", 0, d);
        $display("test power_ctrl done");
        wr(CTRL_OFS, 1, r);
        count(400, xr, pc, pd);
        chk("conv rate", 1, (pc - xr / CDIV) inside {-1, 0, 1});
        chk("disp rate", 1, (pd - xr / DDIV) inside {-1, 0, 1});
        wr(CTRL_OFS, 0, r);
        repeat (10) @(posedge clk);
        count(200, xr, pc, pd);
        chk("ticks off", 0, pc + pd);
        $display("test divider done");
        wr(CTRL_OFS, 1, r);
        wr(CTRL_OFS, 7, r);
        @(posedge clk);
        wdt_req <= 1;
        @(posedge clk);
        wdt_req <= 0;
        wait_rst(1);
        repeat (3) @(posedge clk);
        chk("cpu_en wdt", 0, cpu_en);
        chk("boost wdt", 0, boost);
        rd(STAT_OFS, d, r);
        chk("wdt sticky", 1, d[STAT_WDT_BIT]);
        chk("stat run wdt", 0, d[STAT_RUN_BIT]);
        wr(STAT_OFS, 1 << STAT_WDT_BIT, r);
        rd(STAT_OFS, d, r);
        chk("wdt cleared", 0, d[STAT_WDT_BIT]);
        tick();
        chk("cpu_en after wdt", 1, cpu_en);
        $display("test watchdog done");
        @(posedge clk);
        pin_req <= 1;
        wait_rst(1);
        @(posedge clk);
        chk("cpu_en pin", 0, cpu_en);
        rd(STAT_OFS, d, r);
        chk("stat pin reset", (1 << STAT_RESET_BIT) | (1 << STAT_PIN_BIT), d);
        tick_req <= 1;
        repeat (3) @(posedge clk);
        pin_req <= 0;
        wait_rst(0);
        repeat (10) @(posedge clk);
        chk("no rise yet", 0, cpu_en);
        tick_req <= 0;
        repeat (3) @(posedge clk);
        tick();
        chk("cpu_en next rise", 1, cpu_en);
        $display("test pin_reset done");
        stop_test();
    end
endmodule
